// ### pot_pkg.sv
// package for the two-wire potentiometer command slave
// assumes a 50 MHz ref_clk that oversamples the serial clock
`default_nettype none
package pot_pkg;
  localparam int WIPER_W = 10;
  localparam int TAPS = 1024;
  localparam int NUM_SETTINGS = 4;
  localparam logic [3:0] DEVICE_TYPE_FIELD = 4'hA; // arbitrary value
  localparam logic [2:0] OP_READ_WIPER = 3'h4;
  localparam logic [2:0] OP_WRITE_WIPER = 3'h5;
  localparam logic [2:0] OP_READ_SETTING = 3'h5;
  localparam logic [2:0] OP_WRITE_SETTING = 3'h6;
  localparam logic [2:0] OP_COPY_TO_WIPER = 3'h6;
  localparam logic [2:0] OP_COPY_TO_SETTING = 3'h7;
  localparam int OPCODE_MSB = 7;
  localparam int SEL_MSB = 3;
  localparam int ADDR_STRAP_MSB = 2;
  localparam logic [WIPER_W-1:0] SETTING_RESET = 10'h000;
  localparam int CLK_HZ = 50000000;
  localparam int NV_WRITE_MS = 10;
  // longest time, rounded down
  localparam int NV_WRITE_CYCLES = (CLK_HZ / 1000) * NV_WRITE_MS;
endpackage
`default_nettype wire

// ### tap_decoder.sv
// one-hot tap switch decoder for the wiper position
// assumes the position input is a stable register value
`default_nettype none
module tap_decoder
  import pot_pkg::*;
#(
  parameter int W = WIPER_W
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] position,
  output logic [(1<<W)-1:0] tap_enable
);
  logic [(1<<W)-1:0] onehot_d;

  // binary to one-hot, exactly one bit ever set
  always_comb
  begin
    onehot_d = '0;
    onehot_d[position] = 1'b1;
  end

  // registered so a position change never shows two taps
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      tap_enable <= {{((1<<W)-1){1'b0}}, 1'b1};
    else
      tap_enable <= onehot_d;
  end
endmodule
`default_nettype wire

// ### pot_two_wire_command_slave.sv
// two-wire slave and command interpreter for a digital potentiometer
// assumes scl and sda_in come from pins, asynchronous to ref_clk
`default_nettype none
// Notes on behaviour
// - wiper position decodes to one-hot tap
// - never two tap enables at once
// - data changes only while clock low
// - watch start, ignore bus until seen
// - sender releases data, receiver acks ninth
// - ack matching address, instruction, data bytes
// - stop after nonvolatile write starts write cycle
// - no address ack while writing
// - top address nibble is device type
// - two address bits must match straps
// - address lsb one means read
// - select bits pick one of four settings
// - read, opcode 100 returns wiper position
// - write, opcode 101 loads wiper position
// - read, opcode 101 returns selected setting
// - write, opcode 110 writes selected setting
// - read, opcode 110 copies setting to wiper
// - write, opcode 111 copies wiper to setting
// - sample on scl rise, shift after fall
// - write protect low blocks nonvolatile writes
// - power-up loads wiper from setting zero
// - nonvolatile write ends within bounded time
module pot_two_wire_command_slave
  import pot_pkg::*;
#(
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  input wire logic write_protect_n,
  output logic [TAPS-1:0] tap_enable,
  output logic [WIPER_W-1:0] wiper_position,
  output logic busy
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INSTR, ST_WDATA, ST_RDATA, ST_ACK, ST_RACK, ST_WAIT
  } phase_e;

  typedef struct packed {
    logic [1:0] scl_s;       // scl synchroniser
    logic [1:0] sda_s;       // sda synchroniser
    logic [1:0][2:0] pins_s; // straps and protect, two flops
    logic scl_p;             // previous synced scl
    logic sda_p;             // previous synced sda
    phase_e phase;           // protocol phase
    phase_e after_ack;       // phase after ack bit
    logic [3:0] bit_cnt;     // bits in current byte
    logic [7:0] shift;       // byte shift register
    logic read_dir;          // address lsb
    logic [2:0] opcode;      // instruction opcode
    logic [1:0] sel;         // setting select
    logic byte_idx;          // data byte index
    logic [1:0] hi_bits;     // first data byte bits
    logic ack_drive;         // pull sda low
    logic nv_pending;        // stop starts nv write
    logic [WIPER_W-1:0] nv_value;
    logic [31:0] wr_cnt;     // write cycle counter
    logic booted;            // power-up load done
    logic [WIPER_W-1:0] wiper;
    logic [NUM_SETTINGS-1:0][WIPER_W-1:0] setting;
  } state_s;

  state_s q, d;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] byte_in;
  logic [WIPER_W-1:0] sel_setting;

  // edges from synced copies only
  assign scl_rise = q.scl_s[1] & ~q.scl_p;
  assign scl_fall = ~q.scl_s[1] & q.scl_p;
  assign start_seen = q.scl_s[1] & q.scl_p & q.sda_p & ~q.sda_s[1];
  assign stop_seen = q.scl_s[1] & q.scl_p & ~q.sda_p & q.sda_s[1];
  assign byte_in = {q.shift[6:0], q.sda_s[1]};
  assign sel_setting = q.setting[q.sel];

  // next-state logic
  always_comb
  begin
    d = q;
    d.scl_s = {q.scl_s[0], scl};
    d.sda_s = {q.sda_s[0], sda_in};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    d.pins_s = {q.pins_s[0], {addr_strap_hi, addr_strap_lo, write_protect_n}};
    // power-up recall
    if (!q.booted)
    begin
      d.wiper = q.setting[0];
      d.booted = 1'b1;
    end
    // internal write timer, inputs ignored meanwhile
    if (q.wr_cnt != 32'h0)
    begin
      d.wr_cnt = q.wr_cnt - 32'h1;
      if (q.wr_cnt == 32'h1)
        d.setting[q.sel] = q.nv_value;
    end
    if (q.wr_cnt != 32'h0)
    begin
      // busy: bus released, no address ack
      d.phase = ST_IDLE;
      d.ack_drive = 1'b0;
    end
    else if (stop_seen)
    begin
      d.phase = ST_IDLE;
      d.ack_drive = 1'b0;
      if (q.nv_pending)
      begin
        d.nv_pending = 1'b0;
        d.wr_cnt = (WRITE_CYCLES < 1) ? 32'h1 : 32'(WRITE_CYCLES);
      end
    end
    else if (start_seen)
    begin
      // every command begins here
      d.phase = ST_ADDR;
      d.bit_cnt = 4'h0;
      d.ack_drive = 1'b0;
      d.nv_pending = 1'b0;
    end
    else
    begin
      unique case (q.phase)
        ST_IDLE, ST_WAIT:
        begin
          d.ack_drive = 1'b0;
        end
        ST_ADDR, ST_INSTR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            d.shift = byte_in;
            d.bit_cnt = q.bit_cnt + 4'h1;
            if (q.bit_cnt == 4'h7)
            begin
              d.bit_cnt = 4'h0;
              d.after_ack = ST_WAIT;
              d.phase = ST_ACK;
              if (q.phase == ST_ADDR)
              begin
                if (byte_in[7:4] == DEVICE_TYPE_FIELD &&
                    byte_in[ADDR_STRAP_MSB:1] ==
                      q.pins_s[1][2:1])
                begin
                  d.read_dir = byte_in[0];
                  d.after_ack = ST_INSTR;
                end
                else
                  d.phase = ST_WAIT;
              end
              else if (q.phase == ST_INSTR)
              begin
                d.opcode = byte_in[OPCODE_MSB -: 3];
                d.sel = byte_in[SEL_MSB -: 2];
                d.byte_idx = 1'b0;
                d.after_ack = ST_WAIT;
                if (q.read_dir)
                begin
                  if (d.opcode == OP_READ_WIPER || d.opcode == OP_READ_SETTING)
                    d.after_ack = ST_RDATA;
                  else if (d.opcode == OP_COPY_TO_WIPER)
                    d.wiper = q.setting[byte_in[SEL_MSB -: 2]];
                end
                else if (d.opcode == OP_WRITE_WIPER || d.opcode == OP_WRITE_SETTING)
                  d.after_ack = ST_WDATA;
                else if (d.opcode == OP_COPY_TO_SETTING && q.pins_s[1][0])
                begin
                  d.nv_value = q.wiper;
                  d.nv_pending = 1'b1;
                end
              end
              else
              begin
                // data byte received
                d.byte_idx = 1'b1;
                d.after_ack = q.byte_idx ? ST_WAIT : ST_WDATA;
                if (!q.byte_idx)
                  d.hi_bits = byte_in[1:0];
                else if (q.opcode == OP_WRITE_WIPER)
                  d.wiper = {q.hi_bits, byte_in};
                else if (q.pins_s[1][0])
                begin
                  d.nv_value = {q.hi_bits, byte_in};
                  d.nv_pending = 1'b1;
                end
              end
            end
          end
        end
        ST_ACK:
        begin
          // drive low after fall, release after ninth clock
          if (scl_fall)
          begin
            d.ack_drive = ~q.ack_drive;
            if (q.ack_drive)
            begin
              d.phase = q.after_ack;
              if (q.after_ack == ST_RDATA)
              begin
                d.shift = {6'h00, (q.opcode == OP_READ_WIPER) ?
                  q.wiper[9:8] : sel_setting[9:8]};
                d.ack_drive = ~d.shift[7];
              end
            end
          end
        end
        ST_RDATA:
        begin
          // shift out msb first, change only after fall
          if (scl_fall)
          begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            d.shift = {q.shift[6:0], 1'b0};
            d.ack_drive = ~q.shift[6];
            if (q.bit_cnt == 4'h7)
            begin
              d.bit_cnt = 4'h0;
              d.ack_drive = 1'b0; // release for master ack
              d.phase = ST_RACK;
            end
          end
        end
        ST_RACK:
        begin
          // master ack on ninth rise decides next byte
          if (scl_rise)
          begin
            d.phase = ST_WAIT;
            if (!q.sda_s[1] && !q.byte_idx)
            begin
              d.byte_idx = 1'b1;
              d.phase = ST_ACK;
              d.after_ack = ST_RDATA;
            end
          end
          else if (scl_fall && q.phase == ST_RACK && q.byte_idx)
            d.phase = ST_WAIT;
        end
      endcase
      // second read byte loads low bits on its own first fall
      if (q.phase == ST_ACK && q.after_ack == ST_RDATA && q.byte_idx && scl_fall)
      begin
        d.phase = ST_RDATA;
        d.shift = (q.opcode == OP_READ_WIPER) ? q.wiper[7:0] : sel_setting[7:0];
        d.ack_drive = ~d.shift[7];
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.phase <= ST_IDLE;
      q.after_ack <= ST_IDLE;
      q.setting <= {NUM_SETTINGS{SETTING_RESET}};
    end
    else
      q <= d;
  end

  // open drain: only ever pull low, never drive scl
  assign sda_out = 1'b0;
  assign sda_oe = q.ack_drive;
  assign wiper_position = q.wiper;
  assign busy = (q.wr_cnt != 32'h0);

  tap_decoder #(
    .W(WIPER_W)
  ) u_taps (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .position(q.wiper),
    .tap_enable(tap_enable)
  );
endmodule
`default_nettype wire

// ### pot_bus_master.sv
// two-wire bus master model for the potentiometer slave
// assumes a pull-up on the data line; scl period is 8 ref_clk
`default_nettype none
module pot_bus_master
(
  input wire logic ref_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic m_sda = 1'b1; // master drive, 1 = released
  initial scl = 1'b1; // clock stands high outside frames
  // wired-and of both open-drain parties and the pull-up
  assign sda = m_sda & ~sda_oe;
  // half of the serial clock period
  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask
  // one bit: data moved in scl low, sampled at end of scl high
  task automatic bit_io(input logic b, output logic r);
    @(posedge ref_clk);
    m_sda <= b;
    repeat (3) @(posedge ref_clk);
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
  endtask
  // start from idle: data falls with scl high
  task automatic start();
    half();
    m_sda <= 1'b0;
    half();
    scl <= 1'b0;
  endtask
  // stop: data rises with scl high, then bus left idle
  task automatic stop();
    @(posedge ref_clk);
    m_sda <= 1'b0;
    repeat (3) @(posedge ref_clk);
    scl <= 1'b1;
    half();
    m_sda <= 1'b1;
    half();
  endtask
  // one byte msb first plus the ninth clock
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// ### pot_slave_checker.sv
// port checker for the potentiometer two-wire slave
// assumes bind onto the slave, one ref_clk domain
`default_nettype none
module pot_slave_checker
  import pot_pkg::*;
#(
  parameter int WRITE_CYCLES = 200
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_oe,
  input wire logic write_protect_n,
  input wire logic [TAPS-1:0] tap_enable,
  input wire logic [WIPER_W-1:0] wiper_position,
  input wire logic busy
);
  logic [3:0] gap_q; // cycles since a stop on the pins
  int busy_n_q; // length of the current write
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // stop distance and write length counters
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n) gap_q <= 4'hF;
    else if (scl && sda_in && !$past(sda_in)) gap_q <= 4'h0;
    else if (gap_q != 4'hF) gap_q <= gap_q + 4'h1;
    busy_n_q <= (busy && reset_n) ? busy_n_q + 1 : 0;
  end
  sequence s_stop_recent;
    gap_q < 4'hA;
  endsequence
  AST_ONE_HOT: assert property ($onehot(tap_enable))
    else $error("tap enable not one-hot");
  AST_TAP_MATCH: assert property (tap_enable == (TAPS'(1) << $past(wiper_position)))
    else $error("tap enable does not follow wiper");
  AST_OE_STABLE: assert property (scl [*4] |-> $stable(sda_oe))
    else $error("data moved with clock high");
  AST_OE_RISE: assert property ($rose(sda_oe) |-> !scl && !$past(scl))
    else $error("data driven outside clock low");
  AST_BUSY_STOP: assert property ($rose(busy) |-> s_stop_recent)
    else $error("write began without stop");
  AST_NO_ACK_BUSY: assert property (busy |-> !sda_oe)
    else $error("bus answered while writing");
  AST_BUSY_BOUND: assert property (busy_n_q <= WRITE_CYCLES + 2)
    else $error("write ran too long");
  AST_WP: assert property ($rose(busy) |-> write_protect_n)
    else $error("write under protect");
endmodule
bind pot_two_wire_command_slave pot_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_oe(sda_oe),
  .write_protect_n(write_protect_n), .tap_enable(tap_enable),
  .wiper_position(wiper_position), .busy(busy));
`default_nettype wire

// ### pot_two_wire_command_slave_tb.sv
// self-checking bench for the potentiometer two-wire slave
// assumes pot_pkg, the bus master model and the bound checker
`default_nettype none
module pot_two_wire_command_slave_tb
  import pot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 200; // shortened write time
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic wp_n = 1'b1;
  logic scl, sda, sda_out, sda_oe, busy, ok;
  logic [TAPS-1:0] tap;
  logic [9:0] wiper, v, rv;
  logic [9:0] s [4];
  logic [15:0] seen_q [$];
  logic [15:0] exp_q [$];
  int n_mismatch = 0;
  int checks_done = 0;
  initial forever #10 ref_clk = ~ref_clk;
  pot_two_wire_command_slave #(.WRITE_CYCLES(WC)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_hi(hi), .addr_strap_lo(lo), .write_protect_n(wp_n),
    .tap_enable(tap), .wiper_position(wiper), .busy(busy));
  pot_bus_master m (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic check(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, got, want);
    end
  endtask
  task automatic note(input logic [15:0] got, input logic [15:0] want);
    exp_q.push_back(want);
    seen_q.push_back(got);
  endtask
  // compare each observed value with its oldest note
  initial forever
  begin
    wait (seen_q.size() > 0);
    check(seen_q.pop_front(), exp_q.pop_front());
  end
  function automatic logic [7:0] addr(input logic rw);
    return {DEVICE_TYPE_FIELD, 1'b0, hi, lo, rw};
  endfunction
  // n < 0 address only, 0 no data, 2 two data bytes
  task automatic frame(input logic [7:0] a, input logic [7:0] ins, input int n,
                       input logic [9:0] wv, output logic ak, output logic [9:0] r);
    logic [7:0] q;
    logic k;
    r = '0;
    m.start();
    m.xfer(a, 1'b1, q, ak);
    if (n >= 0) m.xfer(ins, 1'b1, q, k);
    if (n > 0 && a[0])
    begin
      m.xfer(8'hFF, 1'b0, q, k);
      r[9:8] = q[1:0];
      m.xfer(8'hFF, 1'b1, q, k);
      r[7:0] = q;
    end
    else if (n > 0)
    begin
      m.xfer({6'h0, wv[9:8]}, 1'b1, q, k);
      m.xfer(wv[7:0], 1'b1, q, ak);
    end
    m.stop();
  endtask
  // polls at once, then after the write has ended
  task automatic nv_wait(input logic nv);
    logic p;
    logic [9:0] r;
    note(16'(busy), 16'(nv));
    frame(addr(1'b0), 8'h00, -1, 10'h0, p, r);
    note(16'(p), 16'(!nv));
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk);
    frame(addr(1'b0), 8'h00, -1, 10'h0, p, r);
    note(16'(p), 16'h1);
  endtask
  task automatic rd_set(input logic [1:0] k, input logic [9:0] want);
    frame(addr(1'b1), {OP_READ_SETTING, 1'b0, k, 2'b00}, 2, 10'h0, ok, rv);
    note(16'(rv), 16'(want));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h703D));
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    {hi, lo} <= 2'($urandom);
    repeat (6) @(posedge ref_clk);
    note(16'(wiper), 16'(SETTING_RESET));
    note(16'(sda_out), 16'h0);
    $display("test 1 done");
    v = 10'($urandom);
    frame(addr(1'b0), {OP_WRITE_WIPER, 5'h0}, 2, v, ok, rv);
    note(16'(ok), 16'h1);
    note(16'(wiper), 16'(v));
    note(16'(tap === (TAPS'(1) << v)), 16'h1);
    frame(addr(1'b1), {OP_READ_WIPER, 5'h0}, 2, 10'h0, ok, rv);
    note(16'(rv), 16'(v));
    $display("test 2 done");
    foreach (s[k])
    begin
      frame(addr(1'b0) ^ ((k == 3) ? 8'h04 : (8'h80 >> (3 * k))),
            {OP_WRITE_WIPER, 5'h0}, 2, ~v, ok, rv);
      note(16'(ok), 16'h0);
      note(16'(wiper), 16'(v));
      s[k] = 10'($urandom);
      frame(addr(1'b0), {OP_WRITE_SETTING, 1'b0, 2'(k), 2'b00}, 2, s[k], ok, rv);
      nv_wait(1'b1);
      rd_set(2'(k), s[k]);
    end
    $display("test 3 done");
    frame(addr(1'b1), {OP_COPY_TO_WIPER, 1'b0, 2'd2, 2'b00}, 0, 10'h0, ok, rv);
    note(16'(wiper), 16'(s[2]));
    frame(addr(1'b0), {OP_COPY_TO_SETTING, 1'b0, 2'd3, 2'b00}, 0, 10'h0, ok, rv);
    nv_wait(1'b1);
    rd_set(2'd3, s[2]);
    $display("test 4 done");
    wp_n <= 1'b0;
    frame(addr(1'b0), {OP_WRITE_SETTING, 1'b0, 2'd1, 2'b00}, 2, ~s[1], ok, rv);
    nv_wait(1'b0);
    rd_set(2'd1, s[1]);
    wp_n <= 1'b1;
    $display("test 5 done");
    @(posedge ref_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
